// File: core/plb_regs.svh
// Constants for the programmable logic block: widths, counts, reset values.
// Assumes inclusion by its bare name from design files.
`ifndef PLB_REGS_SVH
`define PLB_REGS_SVH
`define PLB_CELL_COUNT   8
`define PLB_TABLE_INPUTS 4
`define PLB_TABLE_DEPTH  16
`define PLB_GCLK_COUNT   8
`define PLB_REG_RESET    1'b0
`define PLB_SR_SET_VAL   1'b1
`endif

// File: core/plb_pkg.sv
// Types for the programmable logic block.
// Assumes nothing beyond a SystemVerilog compiler.
package plb_pkg;
  typedef enum logic {
    PLB_MODE_LOGIC,
    PLB_MODE_ROM
  } plb_mode_t;
  typedef enum logic [1:0] {
    PLB_CFG_IDLE,
    PLB_CFG_LOADING,
    PLB_CFG_WAKEUP,
    PLB_CFG_USER
  } plb_cfg_state_t;
endpackage

// File: core/plb_cell.sv
// One logic cell: four-input table plus carry majority logic.
// Assumes its table contents are held by the parent block.
`timescale 1ns/100ps
`default_nettype none
module plb_cell (
  input  wire logic [15:0] table_bits, // Programmed table entries
  input  wire logic [3:0]  table_in,   // Table select inputs
  input  wire logic        carry_in,   // Fast carry in
  output logic             table_out,  // Combinational table result
  output logic             carry_out   // Fast carry out
);
  // Table lookup, also serves as 16x1 read-only memory
  assign table_out = table_bits[table_in];
  // Majority of carry in and inputs 1 and 2
  assign carry_out = (carry_in & table_in[1]) | (carry_in & table_in[2])
                   | (table_in[1] & table_in[2]);
endmodule
`default_nettype wire

// File: core/plb_block.sv
// Programmable logic block of eight logic cells with shared controls.
// Assumes configuration words arrive on the clock before config_done.
`timescale 1ns/100ps
`default_nettype none
`include "plb_regs.svh"
// Operation
// - Block holds eight cells, each one table and one register.
// - Logic mode: table selects one of 16 entries by inputs.
// - Table usable as sixteen-word one-bit read-only memory.
// - Table contents load only during configuration, never at run time.
// - Each cell is in logic or memory mode, set at configuration.
// - Register is D type; enable and reset each optional.
// - Registers obey device-wide reset asserted after configuration.
// - One clock enable gates all eight registers together.
// - One local set/reset for all; async or sync option, both acting at the clock edge.
// - All registers share one clock, from global buffer or routing.
// - Without set/reset, registers change only by clocked data.
// - Cell output is registered value or bypassed table result.
// - Each cell has carry in and carry out to next cell.
// - Device-wide reset always forces the cleared value.
module plb_block #(
  parameter int CELLS = `PLB_CELL_COUNT
) (
  input  wire logic                clock,          // Block clock (global or routed)
  input  wire logic                reset,          // Device-wide reset, active high
  input  wire logic                cfg_load,       // Configuration write strobe
  input  wire logic [2:0]          cfg_cell,       // Cell selected for config
  input  wire logic [15:0]         cfg_table,      // Table contents
  input  wire logic                cfg_mode_rom,   // Cell uses memory mode
  input  wire logic                cfg_bypass,     // Cell output bypasses register
  input  wire logic                cfg_use_en,     // Block uses clock enable
  input  wire logic                cfg_use_sr,     // Block uses set/reset
  input  wire logic                cfg_sr_async,   // Set/reset asynchronous
  input  wire logic                cfg_sr_set,     // Set/reset sets rather than clears
  input  wire logic                config_done,    // Configuration complete
  input  wire logic [CELLS*4-1:0]  table_in,       // Four table inputs per cell
  input  wire logic                clock_enable,   // Shared clock enable
  input  wire logic                local_set_reset,// Shared local set/reset
  input  wire logic                chain_carry_in, // Fast carry from previous block
  output logic [CELLS-1:0]         cell_out,       // Cell outputs
  output logic                     chain_carry_out,// Fast carry to next block
  output logic                     user_mode_ff    // Block in user operation
);
  // Refuse other sizes at elaboration: the cell index port is three bits wide
  generate
    if (CELLS != `PLB_CELL_COUNT) begin : g_bad_cells
      $error("plb_block serves eight cells only");
    end
  endgenerate

  plb_pkg::plb_cfg_state_t cfg_state_ff;
  plb_pkg::plb_mode_t      mode_ff   [CELLS];
  logic [15:0]             table_ff  [CELLS];
  logic [CELLS-1:0]        bypass_ff;
  logic                    use_en_ff, use_sr_ff, sr_async_ff, sr_set_ff;
  logic [CELLS-1:0]        reg_ff;
  logic [CELLS-1:0]        table_out;
  logic [CELLS:0]          carry;
  logic [CELLS-1:0]        nxt_reg;
  logic                    cell_out_ready;
  logic                    async_sr;
  logic                    chain_out_ff;

  function automatic logic cfg_open(input plb_pkg::plb_cfg_state_t st);
    return (st == plb_pkg::PLB_CFG_IDLE) || (st == plb_pkg::PLB_CFG_LOADING);
  endfunction

  // Configuration sequence: load, wake-up reset, then user operation
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_state_ff <= plb_pkg::PLB_CFG_IDLE;
    end else begin
      case (cfg_state_ff)
        plb_pkg::PLB_CFG_IDLE: begin
          if (cfg_load) cfg_state_ff <= plb_pkg::PLB_CFG_LOADING;
          else if (config_done) cfg_state_ff <= plb_pkg::PLB_CFG_WAKEUP;
        end
        plb_pkg::PLB_CFG_LOADING: begin
          if (config_done) cfg_state_ff <= plb_pkg::PLB_CFG_WAKEUP;
        end
        plb_pkg::PLB_CFG_WAKEUP: cfg_state_ff <= plb_pkg::PLB_CFG_USER;
        plb_pkg::PLB_CFG_USER:   cfg_state_ff <= plb_pkg::PLB_CFG_USER;
        default:                 cfg_state_ff <= plb_pkg::PLB_CFG_IDLE;
      endcase
    end
  end

  // Table and mode writes accepted only while configuring
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CELLS; i++) begin
        table_ff[i] <= 16'h0000;
        mode_ff[i]  <= plb_pkg::PLB_MODE_LOGIC;
      end
      bypass_ff <= '0;
    end else if (cfg_load && cfg_open(cfg_state_ff)) begin
      table_ff[cfg_cell]  <= cfg_table;
      mode_ff[cfg_cell]   <= cfg_mode_rom ? plb_pkg::PLB_MODE_ROM : plb_pkg::PLB_MODE_LOGIC;
      bypass_ff[cfg_cell] <= cfg_bypass;
    end
  end

  // Block-wide control options, also fixed at configuration
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      use_en_ff   <= 1'b0;
      use_sr_ff   <= 1'b0;
      sr_async_ff <= 1'b0;
      sr_set_ff   <= 1'b0;
    end else if (cfg_load && cfg_open(cfg_state_ff)) begin
      use_en_ff   <= cfg_use_en;
      use_sr_ff   <= cfg_use_sr;
      sr_async_ff <= cfg_sr_async;
      sr_set_ff   <= cfg_sr_set;
    end
  end

  // Eight cells with a ripple carry chain
  assign carry[0] = chain_carry_in;
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      plb_cell u_cell (
        .table_bits (table_ff[g]),
        .table_in   (table_in[g*4 +: 4]),
        .carry_in   (carry[g]),
        .table_out  (table_out[g]),
        .carry_out  (carry[g+1])
      );
    end
  endgenerate

  assign cell_out_ready = (cfg_state_ff == plb_pkg::PLB_CFG_USER);
  // Asynchronous set/reset path, only when configured so
  assign async_sr = use_sr_ff && sr_async_ff && local_set_reset && cell_out_ready;

  // Next register value, one place for every term so that the output
  // flops of registered cells and the cell registers can never disagree.
  // Priority: configuration clear, then set/reset, then enabled data.
  // Holding is the default, which is what a low enable asks for.
  always_comb begin
    nxt_reg = reg_ff;
    if (!cell_out_ready) begin
      nxt_reg = {CELLS{`PLB_REG_RESET}};
    end else if (async_sr) begin
      nxt_reg = sr_set_ff ? {CELLS{`PLB_SR_SET_VAL}} : {CELLS{`PLB_REG_RESET}};
    end else if (use_sr_ff && !sr_async_ff && local_set_reset) begin
      nxt_reg = sr_set_ff ? {CELLS{`PLB_SR_SET_VAL}} : {CELLS{`PLB_REG_RESET}};
    end else if (!use_en_ff || clock_enable) begin
      nxt_reg = table_out;
    end
  end

  // Cell registers; async set/reset is folded into nxt_reg, taken at the clock edge.
  // Device reset and wake-up always clear, whatever the variant.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_ff <= {CELLS{`PLB_REG_RESET}};
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  // Output flops: registered value or one-cycle-late bypass of table
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cell_out     <= '0;
      chain_out_ff <= 1'b0;
      user_mode_ff <= 1'b0;
    end else begin
      for (int i = 0; i < CELLS; i++) begin
        cell_out[i] <= bypass_ff[i] ? table_out[i] : nxt_reg[i];
      end
      chain_out_ff <= carry[CELLS];
      user_mode_ff <= cell_out_ready;
    end
  end
  assign chain_carry_out = chain_out_ff;

  // Checks
  chk_hold_no_en: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready && use_en_ff && !clock_enable && !(use_sr_ff && local_set_reset)
    && $past(cell_out_ready) |=> reg_ff == $past(reg_ff))
    else $error("registers changed with enable low");
  chk_sync_clear: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready && use_sr_ff && local_set_reset && !sr_set_ff
    |=> reg_ff == '0)
    else $error("set/reset did not clear");
  chk_wake_clear: assert property (@(posedge clock) disable iff (reset)
    cfg_state_ff == plb_pkg::PLB_CFG_WAKEUP |=> reg_ff == '0)
    else $error("wake-up did not clear registers");
  chk_no_run_load: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready ##1 cell_out_ready |-> $stable(table_ff[0]))
    else $error("table changed at run time");
  chk_carry_major: assert property (@(posedge clock) disable iff (reset)
    carry[1] == ((carry[0] & table_in[1]) | (carry[0] & table_in[2])
    | (table_in[1] & table_in[2])))
    else $error("carry not majority");
  chk_chain_out: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> chain_carry_out == $past(carry[CELLS]))
    else $error("chain carry out wrong");
  chk_table_sel: assert property (@(posedge clock) disable iff (reset)
    table_out[0] == table_ff[0][table_in[3:0]])
    else $error("table selection wrong");
  chk_bypass_out: assert property (@(posedge clock) disable iff (reset)
    bypass_ff[7] |=> cell_out[7] == $past(table_out[7]))
    else $error("bypass output wrong");
  // A registered cell shows exactly its register
  chk_out_register: assert property (@(posedge clock) disable iff (reset)
    !bypass_ff[0] |=> cell_out[0] == reg_ff[0])
    else $error("registered output differs from register");
  chk_load_data: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready && !(use_sr_ff && local_set_reset) && (!use_en_ff || clock_enable)
    |=> reg_ff == $past(table_out))
    else $error("register missed clocked data");
  cov_user: cover property (@(posedge clock) disable iff (reset) cell_out_ready);
  cov_rom: cover property (@(posedge clock) disable iff (reset)
    mode_ff[0] == plb_pkg::PLB_MODE_ROM && cell_out_ready);
  cov_async: cover property (@(posedge clock) disable iff (reset) async_sr);
  cov_ripple: cover property (@(posedge clock) disable iff (reset) chain_carry_in && carry[CELLS]);

  // Asynchronous variant: clear or preset lands on the next edge
  chk_async_clear: assert property (@(posedge clock) disable iff (reset)
    async_sr && !sr_set_ff |=> reg_ff == '0)
    else $error("async set/reset did not clear");
  chk_async_set: assert property (@(posedge clock) disable iff (reset)
    async_sr && sr_set_ff |=> reg_ff == '1)
    else $error("async set/reset did not set");

  // Synchronous set variant
  chk_sync_set: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready && use_sr_ff && !sr_async_ff && local_set_reset && sr_set_ff
    |=> reg_ff == '1)
    else $error("sync set/reset did not set");

  // Outside user operation the registers always sit cleared
  chk_cfg_clear: assert property (@(posedge clock) disable iff (reset)
    !cell_out_ready |=> reg_ff == '0)
    else $error("registers not cleared during configuration");

  // Wake-up lasts one cycle and user operation is left only by reset
  chk_wake_next: assert property (@(posedge clock) disable iff (reset)
    cfg_state_ff == plb_pkg::PLB_CFG_WAKEUP |=> cfg_state_ff == plb_pkg::PLB_CFG_USER)
    else $error("wake-up did not lead to user operation");
  chk_user_stays: assert property (@(posedge clock) disable iff (reset)
    cfg_state_ff == plb_pkg::PLB_CFG_USER |=> cfg_state_ff == plb_pkg::PLB_CFG_USER)
    else $error("user operation left without reset");

  // The status flag is the state, one cycle late
  chk_user_flag: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> user_mode_ff == $past(cell_out_ready))
    else $error("user flag out of step");

  // Cell mode and bypass choice frozen once running
  chk_mode_frozen: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready ##1 cell_out_ready |-> $stable(mode_ff[0]) && $stable(bypass_ff))
    else $error("cell mode changed at run time");

  // Block options frozen once running
  chk_opts_frozen: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready ##1 cell_out_ready
    |-> $stable(use_en_ff) && $stable(use_sr_ff) && $stable(sr_async_ff)
    && $stable(sr_set_ff))
    else $error("block options changed at run time");

  // Enable low with no set/reset: no register moves
  chk_en_hold: assert property (@(posedge clock) disable iff (reset)
    cell_out_ready && use_en_ff && !clock_enable && !local_set_reset
    |=> $stable(reg_ff))
    else $error("enable low did not hold all registers");

  // Per-cell table and carry checks, one set for each cell of the chain
  generate
    for (g = 0; g < CELLS; g++) begin : g_chk
      chk_cell_table: assert property (@(posedge clock) disable iff (reset)
        table_out[g] == table_ff[g][table_in[g*4 +: 4]])
        else $error("cell table selection wrong");
      chk_cell_carry: assert property (@(posedge clock) disable iff (reset)
        carry[g+1] == ((carry[g] & table_in[g*4+1]) | (carry[g] & table_in[g*4+2])
        | (table_in[g*4+1] & table_in[g*4+2])))
        else $error("cell carry not majority");
    end
  endgenerate

  // Sync set/reset seen in use
  cov_sync: cover property (@(posedge clock) disable iff (reset)
    cell_out_ready && use_sr_ff && !sr_async_ff && local_set_reset);
endmodule
`default_nettype wire

// File: test/plb_fabric.sv
// Routing fabric model that feeds table inputs and fast carry into the block.
// Assumes the bench presents new values between clock edges.
`timescale 1ns/100ps
`default_nettype none
module plb_fabric (
  input  wire logic        clock,    // Block clock
  input  wire logic        reset,    // Device-wide reset
  input  wire logic [31:0] drive_in, // Requested table inputs
  input  wire logic        drive_ci, // Requested carry in
  output logic [31:0]      table_in, // Routed table inputs
  output logic             carry_in  // Routed fast carry
);
  // Launch just after the edge, like a routing flop with clock-to-out delay
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      table_in <= #1 32'h0;
      carry_in <= #1 1'b0;
    end else begin
      table_in <= #1 drive_in;
      carry_in <= #1 drive_ci;
    end
  end
endmodule
`default_nettype wire

// File: test/programmable_logic_block_bench.sv
// Self-checking bench for the logic block: configure, sweep, control, carry.
// Assumes the fabric model drives table inputs and carry into the block.
`timescale 1ns/100ps
`default_nettype none
module programmable_logic_block_bench;
  logic        clock, reset, cfg_load, cfg_mode_rom, cfg_bypass, config_done;
  logic        cfg_use_en, cfg_use_sr, cfg_sr_async, cfg_sr_set, en, sr, dci, ci_w, co;
  logic [2:0]  cfg_cell;
  logic [15:0] cfg_table;
  logic [31:0] drv, tin_w;
  logic [7:0]  cell_out, e5, e15;
  logic        user_mode_ff;
  int          bad_count, n_checks, c, v, k;
  logic [31:0] pats [4] = '{32'h0, 32'h66666666, 32'h22222222, 32'h24242424};

  plb_fabric u_plb_fabric (.clock(clock), .reset(reset), .drive_in(drv), .drive_ci(dci),
    .table_in(tin_w), .carry_in(ci_w));
  plb_block u_plb_block (.clock(clock), .reset(reset), .cfg_load(cfg_load),
    .cfg_cell(cfg_cell), .cfg_table(cfg_table), .cfg_mode_rom(cfg_mode_rom),
    .cfg_bypass(cfg_bypass), .cfg_use_en(cfg_use_en), .cfg_use_sr(cfg_use_sr),
    .cfg_sr_async(cfg_sr_async), .cfg_sr_set(cfg_sr_set), .config_done(config_done),
    .table_in(tin_w), .clock_enable(en), .local_set_reset(sr), .chain_carry_in(ci_w),
    .cell_out(cell_out), .chain_carry_out(co), .user_mode_ff(user_mode_ff));

  // Distinct table per cell so a swapped cell index shows up
  function automatic logic [15:0] tbl(input int n);
    return 16'h6996 ^ (16'h0101 << n);
  endfunction
  function automatic logic [7:0] exp_out(input int val);
    logic [7:0] r;
    logic [15:0] t;
    for (int n = 0; n < 8; n++) begin
      t = tbl(n);
      r[n] = t[val];
    end
    return r;
  endfunction
  // Ripple majority through the eight cells
  function automatic logic carry_exp(input logic [31:0] t, input logic ci);
    logic cc;
    cc = ci;
    for (int n = 0; n < 8; n++) cc = (t[4*n+1] & t[4*n+2]) | ((t[4*n+1] | t[4*n+2]) & cc);
    return cc;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] expv);
    n_checks++;
    if (got !== expv) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Whole run needs about 100 cycles
  initial begin
    repeat (2000) @(posedge clock);
    bad_count++;
    end_of_test();
  end

  initial begin
    bad_count = 0;
    n_checks = 0;
    reset = 1'b1;
    {cfg_load, cfg_mode_rom, cfg_bypass, config_done, sr, dci, cfg_sr_async} = 7'h00;
    {cfg_use_en, cfg_use_sr, cfg_sr_set, en} = 4'hf;
    cfg_cell = 3'h0;
    cfg_table = 16'h0;
    drv = 32'h0;
    e5 = exp_out(5);
    e15 = exp_out(15);
    step(2);
    reset = 1'b0;
    check({user_mode_ff, cell_out[6:0]}, 8'h00);
    // Back-to-back loads, odd cells in memory mode, top cell bypassed
    for (c = 0; c < 8; c++) begin
      cfg_load = 1'b1;
      cfg_cell = c[2:0];
      cfg_table = tbl(c);
      cfg_mode_rom = c[0];
      cfg_bypass = (c == 7);
      step(1);
    end
    cfg_load = 1'b0;
    config_done = 1'b1;
    k = 0;
    while (user_mode_ff !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    check({7'h0, user_mode_ff}, 8'h01);
    for (v = 0; v < 16; v++) begin
      drv = {8{v[3:0]}};
      step(3);
      check(cell_out, exp_out(v));
    end
    // Enable low: registered cells hold, bypassed cell follows its table
    en = 1'b0;
    drv = {8{4'h5}};
    step(3);
    check(cell_out, {e5[7], e15[6:0]});
    sr = 1'b1;
    step(3);
    check(cell_out, {e5[7], 7'h7f});
    sr = 1'b0;
    en = 1'b1;
    // A load after configuration must not alter any table
    cfg_load = 1'b1;
    cfg_cell = 3'h0;
    cfg_table = ~tbl(0);
    step(1);
    cfg_load = 1'b0;
    step(3);
    check(cell_out, exp_out(5));
    for (k = 0; k < 4; k++) begin
      drv = pats[k];
      dci = k[0];
      step(3);
      check({7'h0, co}, {7'h0, carry_exp(pats[k], k[0])});
    end
    // Second reset in mid-run clears every output
    reset = 1'b1;
    config_done = 1'b0;
    step(1);
    check(cell_out | {7'h0, user_mode_ff | co}, 8'h00);
    reset = 1'b0;
    // Reconfigure: asynchronous clearing set/reset, nothing bypassed
    for (c = 0; c < 8; c++) begin
      cfg_load = 1'b1;
      cfg_cell = c[2:0];
      cfg_table = tbl(c);
      cfg_mode_rom = 1'b0;
      cfg_bypass = 1'b0;
      cfg_sr_async = 1'b1;
      cfg_sr_set = 1'b0;
      step(1);
    end
    cfg_load = 1'b0;
    config_done = 1'b1;
    k = 0;
    while (user_mode_ff !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    drv = {8{4'hf}};
    step(3);
    check(cell_out, e15);
    sr = 1'b1;
    step(3);
    check(cell_out, 8'h00);
    sr = 1'b0;
    step(3);
    check(cell_out, e15);
    end_of_test();
  end
endmodule
`default_nettype wire
